// file: common/pls_pkg.sv
/*
 * Shared constants for the link status export block: APB map, field
 * positions, reset values and training state codes.
 * Assumes a 32-bit APB with byte addresses on paddr.
 */
package pls_pkg;
    localparam int PLS_ADDR_W = 8;
    localparam int PLS_DATA_W = 32;
    localparam int PLS_LTSSM_W = 6;
    localparam int PLS_FN_W = 4;

    // Register byte offsets
    localparam logic [PLS_ADDR_W-1:0] PLS_OFF_CTRL = 8'h00;
    localparam logic [PLS_ADDR_W-1:0] PLS_OFF_RCB = 8'h04;
    localparam logic [PLS_ADDR_W-1:0] PLS_OFF_TPH0 = 8'h08;
    localparam logic [PLS_ADDR_W-1:0] PLS_OFF_TPH1 = 8'h0C;
    localparam logic [PLS_ADDR_W-1:0] PLS_OFF_LSTS = 8'h10;
    localparam logic [PLS_ADDR_W-1:0] PLS_OFF_LTSSM = 8'h14;

    // Control fields
    localparam int PLS_CTRL_W = 4;
    localparam int PLS_CTRL_ROOT = 0;
    localparam int PLS_CTRL_BWM_IE = 1;
    localparam int PLS_CTRL_ABW_IE = 2;
    localparam int PLS_CTRL_EQ_IE = 3;
    localparam logic [PLS_CTRL_W-1:0] PLS_CTRL_RST = 4'h0;

    // Link status fields, write one to clear
    localparam int PLS_STS_W = 3;
    localparam int PLS_STS_BWM = 0;
    localparam int PLS_STS_ABW = 1;
    localparam int PLS_STS_EQ = 2;
    localparam logic [PLS_STS_W-1:0] PLS_STS_RST = 3'h0;

    localparam logic [PLS_FN_W-1:0] PLS_RCB_RST = 4'h0;
    localparam int PLS_TPH_EN_BIT = 8;
    localparam int PLS_LTSSM_KNOWN_BIT = 8;

    typedef enum logic [PLS_LTSSM_W-1:0] {
        PLS_DET_QUIET = 6'h00, PLS_DET_ACTIVE = 6'h01,
        PLS_POLL_ACTIVE = 6'h02, PLS_POLL_COMPL = 6'h03, PLS_POLL_CFG = 6'h04,
        PLS_CFG_LW_START = 6'h05, PLS_CFG_LW_ACCEPT = 6'h06,
        PLS_CFG_LN_ACCEPT = 6'h07, PLS_CFG_LN_WAIT = 6'h08,
        PLS_CFG_COMPLETE = 6'h09, PLS_CFG_IDLE = 6'h0A,
        PLS_REC_RCVRLOCK = 6'h0B, PLS_REC_RCVRCFG = 6'h0C,
        PLS_REC_IDLE = 6'h0D, PLS_REC_SPEED = 6'h0E,
        PLS_L0 = 6'h10, PLS_RXL0S_ENTRY = 6'h11, PLS_RXL0S_IDLE = 6'h12,
        PLS_RXL0S_FTS = 6'h13, PLS_TXL0S_ENTRY = 6'h14, PLS_TXL0S_IDLE = 6'h15,
        PLS_TXL0S_FTS = 6'h16, PLS_L2_IDLE = 6'h19, PLS_L2_TXWAKE = 6'h1A,
        PLS_DISABLED = 6'h20, PLS_LPBK_ENTRY_LEAD = 6'h21,
        PLS_LPBK_ACTIVE_LEAD = 6'h22, PLS_LPBK_EXIT_LEAD = 6'h23,
        PLS_LPBK_ENTRY_FOLLOW = 6'h24, PLS_LPBK_EXIT_FOLLOW = 6'h25,
        PLS_HOT_RESET = 6'h27, PLS_REC_EQ_PH1 = 6'h28,
        PLS_REC_EQ_PH2 = 6'h2A, PLS_REC_EQ_PH3 = 6'h2B
    } pls_ltssm_t;

    // True for any code of the training state list
    function automatic logic pls_ltssm_known(input logic [PLS_LTSSM_W-1:0] code);
        logic known;
        known = 1'b0;
        case (code)
            PLS_DET_QUIET, PLS_DET_ACTIVE, PLS_POLL_ACTIVE, PLS_POLL_COMPL,
            PLS_POLL_CFG, PLS_CFG_LW_START, PLS_CFG_LW_ACCEPT, PLS_CFG_LN_ACCEPT,
            PLS_CFG_LN_WAIT, PLS_CFG_COMPLETE, PLS_CFG_IDLE, PLS_REC_RCVRLOCK,
            PLS_REC_RCVRCFG, PLS_REC_IDLE, PLS_REC_SPEED, PLS_L0,
            PLS_RXL0S_ENTRY, PLS_RXL0S_IDLE, PLS_RXL0S_FTS, PLS_TXL0S_ENTRY,
            PLS_TXL0S_IDLE, PLS_TXL0S_FTS, PLS_L2_IDLE, PLS_L2_TXWAKE,
            PLS_DISABLED, PLS_LPBK_ENTRY_LEAD, PLS_LPBK_ACTIVE_LEAD,
            PLS_LPBK_EXIT_LEAD, PLS_LPBK_ENTRY_FOLLOW, PLS_LPBK_EXIT_FOLLOW,
            PLS_HOT_RESET, PLS_REC_EQ_PH1, PLS_REC_EQ_PH2, PLS_REC_EQ_PH3:
                known = 1'b1;
            default:
                known = 1'b0;
        endcase
        return known;
    endfunction
endpackage

// file: src/pls_link_status_outputs.sv
/*
 * Link status export: training state code, completion boundary bits,
 * link change notice and TPH requester enables, with an APB register
 * file holding the mirrored configuration bits.
 * Assumes training state and link events come from logic on clk_sys.
 */
`timescale 1ns/1ps
module pls_link_status_outputs
    import pls_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pls_pkg::PLS_ADDR_W-1:0] paddr,
    input wire logic [pls_pkg::PLS_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [pls_pkg::PLS_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link layer sources
    input wire logic [pls_pkg::PLS_LTSSM_W-1:0] ltssmIn,
    input wire logic localBwEvt,
    input wire logic remoteBwEvt,
    input wire logic eqReqEvt,
    // User side status
    output logic [pls_pkg::PLS_LTSSM_W-1:0] ltssmState,
    output logic [pls_pkg::PLS_FN_W-1:0] rcbStatus,
    output logic link_change_notice,
    output logic [pls_pkg::PLS_FN_W-1:0] tphRequesterEnable
);
    import pls_pkg::*;

    logic [PLS_CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [PLS_FN_W-1:0] rcb_q, rcb_d;
    logic tph0_q, tph0_d, tph1_q, tph1_d;
    logic [PLS_STS_W-1:0] sts_q, sts_d;
    logic [PLS_DATA_W-1:0] prdata_q, prdata_d;
    logic [PLS_LTSSM_W-1:0] ltssm_q, ltssm_d;
    logic [PLS_FN_W-1:0] rcbOut_q, rcbOut_d;
    logic notice_q, notice_d;
    logic [PLS_FN_W-1:0] tphOut_q, tphOut_d;
    logic accPhase, setupPhase, addrHit, wrEn;
    logic [PLS_DATA_W-1:0] wrMask, rdData;
    logic [PLS_STS_W-1:0] stsEvt, stsIe;

    assign setupPhase = psel & ~penable;
    assign accPhase = psel & penable;
    assign addrHit = (paddr == PLS_OFF_CTRL) || (paddr == PLS_OFF_RCB) ||
                     (paddr == PLS_OFF_TPH0) || (paddr == PLS_OFF_TPH1) ||
                     (paddr == PLS_OFF_LSTS) || (paddr == PLS_OFF_LTSSM);
    // Zero wait states; data for reads is captured in the setup cycle
    assign pready = accPhase;
    assign pslverr = accPhase & ~addrHit;
    assign wrEn = accPhase & pwrite & addrHit;
    assign wrMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign prdata = prdata_q;

    assign stsEvt[PLS_STS_BWM] = localBwEvt;
    assign stsEvt[PLS_STS_ABW] = remoteBwEvt;
    assign stsEvt[PLS_STS_EQ] = eqReqEvt;
    assign stsIe[PLS_STS_BWM] = ctrl_q[PLS_CTRL_BWM_IE];
    assign stsIe[PLS_STS_ABW] = ctrl_q[PLS_CTRL_ABW_IE];
    assign stsIe[PLS_STS_EQ] = ctrl_q[PLS_CTRL_EQ_IE];

    function automatic logic [PLS_DATA_W-1:0] wmerge(input logic [PLS_DATA_W-1:0] oldV,
                                                    input logic [PLS_DATA_W-1:0] newV,
                                                    input logic [PLS_DATA_W-1:0] mask);
        return (oldV & ~mask) | (newV & mask);
    endfunction

    // Register file and status bits
    always_comb
    begin
        logic [PLS_DATA_W-1:0] tmp;
        logic [PLS_STS_W-1:0] clr;
        tmp = '0;
        clr = '0;
        ctrl_d = ctrl_q;
        rcb_d = rcb_q;
        tph0_d = tph0_q;
        tph1_d = tph1_q;
        if (wrEn)
        begin
            case (paddr)
                PLS_OFF_CTRL:
                begin
                    tmp = wmerge({{(PLS_DATA_W-PLS_CTRL_W){1'b0}}, ctrl_q}, pwdata, wrMask);
                    ctrl_d = tmp[PLS_CTRL_W-1:0];
                end
                PLS_OFF_RCB:
                begin
                    tmp = wmerge({{(PLS_DATA_W-PLS_FN_W){1'b0}}, rcb_q}, pwdata, wrMask);
                    rcb_d = tmp[PLS_FN_W-1:0];
                end
                PLS_OFF_TPH0:
                begin
                    if (pstrb[PLS_TPH_EN_BIT/8])
                    begin
                        tph0_d = pwdata[PLS_TPH_EN_BIT];
                    end
                end
                PLS_OFF_TPH1:
                begin
                    if (pstrb[PLS_TPH_EN_BIT/8])
                    begin
                        tph1_d = pwdata[PLS_TPH_EN_BIT];
                    end
                end
                PLS_OFF_LSTS:
                begin
                    tmp = pwdata & wrMask;
                    clr = tmp[PLS_STS_W-1:0];
                end
                default:
                begin
                    tmp = '0;
                end
            endcase
        end
        // A fresh event outlives a clear in the same cycle
        sts_d = (sts_q & ~clr) | stsEvt;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ctrl_q <= PLS_CTRL_RST;
            rcb_q <= PLS_RCB_RST;
            tph0_q <= 1'b0;
            tph1_q <= 1'b0;
            sts_q <= PLS_STS_RST;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            rcb_q <= rcb_d;
            tph0_q <= tph0_d;
            tph1_q <= tph1_d;
            sts_q <= sts_d;
        end
    end

    // Read data and user side outputs
    always_comb
    begin
        rdData = '0;
        case (paddr)
            PLS_OFF_CTRL: rdData[PLS_CTRL_W-1:0] = ctrl_q;
            PLS_OFF_RCB: rdData[PLS_FN_W-1:0] = rcb_q;
            PLS_OFF_TPH0: rdData[PLS_TPH_EN_BIT] = tph0_q;
            PLS_OFF_TPH1: rdData[PLS_TPH_EN_BIT] = tph1_q;
            PLS_OFF_LSTS: rdData[PLS_STS_W-1:0] = sts_q;
            PLS_OFF_LTSSM:
            begin
                rdData[PLS_LTSSM_W-1:0] = ltssm_q;
                rdData[PLS_LTSSM_KNOWN_BIT] = pls_ltssm_known(ltssm_q);
            end
            default: rdData = '0;
        endcase
        prdata_d = (setupPhase && !pwrite) ? rdData : prdata_q;
        ltssm_d = ltssmIn;
        // Bit value 0 means 64-byte, 1 means 128-byte boundary
        if (ctrl_q[PLS_CTRL_ROOT])
        begin
            rcbOut_d = {{(PLS_FN_W-1){1'b0}}, rcb_q[0]};
        end
        else
        begin
            rcbOut_d = rcb_q;
        end
        notice_d = ctrl_q[PLS_CTRL_ROOT] & |(sts_q & stsIe);
        tphOut_d = {2'b00, tph1_q, tph0_q};
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            prdata_q <= '0;
            ltssm_q <= '0;
            rcbOut_q <= '0;
            notice_q <= 1'b0;
            tphOut_q <= '0;
        end
        else
        begin
            prdata_q <= prdata_d;
            ltssm_q <= ltssm_d;
            rcbOut_q <= rcbOut_d;
            notice_q <= notice_d;
            tphOut_q <= tphOut_d;
        end
    end

    assign ltssmState = ltssm_q;
    assign rcbStatus = rcbOut_q;
    assign link_change_notice = notice_q;
    assign tphRequesterEnable = tphOut_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    chk_ltssm_follow: assert property (##1 ltssmState == $past(ltssmIn))
        else $error("training state output does not follow source");
    chk_rcb_endpoint: assert property (!ctrl_q[PLS_CTRL_ROOT] |=> rcbStatus == $past(rcb_q))
        else $error("endpoint boundary bits wrong");
    chk_rcb_root: assert property (ctrl_q[PLS_CTRL_ROOT] |=>
        rcbStatus[PLS_FN_W-1:1] == '0 && rcbStatus[0] == $past(rcb_q[0]))
        else $error("root boundary bits wrong");
    chk_notice_endpoint: assert property (!ctrl_q[PLS_CTRL_ROOT] |=> !link_change_notice)
        else $error("notice active in endpoint mode");
    chk_local_bw_notice: assert property (
        localBwEvt && ctrl_q[PLS_CTRL_ROOT] && ctrl_q[PLS_CTRL_BWM_IE]
        ##1 ctrl_q[PLS_CTRL_ROOT] && ctrl_q[PLS_CTRL_BWM_IE] |=> link_change_notice)
        else $error("local bandwidth change gave no notice");
    chk_remote_bw_notice: assert property (
        remoteBwEvt && ctrl_q[PLS_CTRL_ROOT] && ctrl_q[PLS_CTRL_ABW_IE]
        ##1 ctrl_q[PLS_CTRL_ROOT] && ctrl_q[PLS_CTRL_ABW_IE] |=> link_change_notice)
        else $error("autonomous bandwidth change gave no notice");
    chk_eq_status: assert property (eqReqEvt |=> sts_q[PLS_STS_EQ])
        else $error("equalization request not recorded");
    chk_set_wins: assert property (stsEvt != '0 && wrEn && paddr == PLS_OFF_LSTS
        |=> (sts_q & $past(stsEvt)) == $past(stsEvt))
        else $error("event lost to a clear");
    chk_notice_masked: assert property (ctrl_q[PLS_CTRL_ROOT] && (sts_q & stsIe) == '0
        |=> !link_change_notice)
        else $error("notice without enabled status");
    chk_tph_map: assert property (##1 tphRequesterEnable ==
        {2'b00, $past(tph1_q), $past(tph0_q)})
        else $error("TPH enable bits wrong");
    chk_steady_out: assert property ($stable(rcb_q) && $stable(ctrl_q)
        |=> $stable(rcbStatus))
        else $error("boundary output moved without cause");

    cov_root_notice: cover property (ctrl_q[PLS_CTRL_ROOT] ##1 link_change_notice);
    cov_eq_req: cover property (eqReqEvt && ctrl_q[PLS_CTRL_EQ_IE]);
    cov_ltssm_l0: cover property (ltssmState == PLS_L0);
    cov_sts_clear: cover property (sts_q != '0 ##1 sts_q == '0);
endmodule

// file: dv/pls_link_model.sv
/*
 * Link layer source model: training state code and one-cycle event pulses.
 * Assumes the bench commands it on clk_sys rising edges.
 */
`timescale 1ns/1ps
module pls_link_model
    import pls_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Bench commands
    input wire logic [pls_pkg::PLS_LTSSM_W-1:0] stateCmd,
    input wire logic [2:0] evtCmd,
    // Link sources
    output logic [pls_pkg::PLS_LTSSM_W-1:0] ltssmIn,
    output logic localBwEvt,
    output logic remoteBwEvt,
    output logic eqReqEvt
);
    // Registered, so sources change just after an edge like real link logic
    always_ff @(posedge clk_sys)
    begin
        ltssmIn <= sys_rst ? 6'h00 : stateCmd;
        localBwEvt <= !sys_rst && evtCmd[0];
        remoteBwEvt <= !sys_rst && evtCmd[1];
        eqReqEvt <= !sys_rst && evtCmd[2];
    end
endmodule

// file: dv/tb_top.sv
/*
 * Bench for the link status export block over APB.
 * Assumes pls_pkg and pls_link_model are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
    import pls_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata, rdData;
    logic pready, pslverr, rdErr;
    logic [5:0] stateCmd = 6'h00;
    logic [2:0] evtCmd = 3'h0;
    logic [5:0] ltssmIn, ltssmState;
    logic localBwEvt, remoteBwEvt, eqReqEvt, link_change_notice;
    logic [3:0] rcbStatus, tphRequesterEnable;
    int mismatches = 0;
    int n_tests = 0;
    logic [5:0] codes [9] = '{6'h01, 6'h03, 6'h08, 6'h0D, 6'h0E, 6'h10, 6'h20, 6'h27, 6'h2B};

    always #5 clk_sys = ~clk_sys;

    pls_link_model link (.clk_sys(clk_sys), .sys_rst(sys_rst), .stateCmd(stateCmd),
        .evtCmd(evtCmd), .ltssmIn(ltssmIn), .localBwEvt(localBwEvt),
        .remoteBwEvt(remoteBwEvt), .eqReqEvt(eqReqEvt));

    pls_link_status_outputs dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ltssmIn(ltssmIn),
        .localBwEvt(localBwEvt), .remoteBwEvt(remoteBwEvt), .eqReqEvt(eqReqEvt),
        .ltssmState(ltssmState), .rcbStatus(rcbStatus),
        .link_change_notice(link_change_notice), .tphRequesterEnable(tphRequesterEnable));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask

    // Settle past the edge so outputs are read after their updates land
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            mismatches++;
            final_report();
        end
    endtask

    task automatic pulse(input int i);
        @(posedge clk_sys);
        evtCmd <= 3'(1 << i);
        @(posedge clk_sys);
        evtCmd <= 3'h0;
    endtask

    task automatic test_ltssm();
        foreach (codes[i])
        begin
            @(posedge clk_sys);
            stateCmd <= codes[i];
            cyc(3);
            chk(32'(ltssmState), 32'(codes[i]));
            apb(1'b0, PLS_OFF_LTSSM, 32'h0);
            chk(rdData & 32'h1FF, {23'h0, 1'b1, 2'b00, codes[i]});
        end
        $display("test_ltssm done");
    endtask

    task automatic test_rcb_tph();
        apb(1'b1, PLS_OFF_RCB, 32'h0000000A);
        apb(1'b1, PLS_OFF_CTRL, 32'h0);
        cyc(2);
        chk(32'(rcbStatus), 32'hA);
        apb(1'b1, PLS_OFF_CTRL, 32'h1);
        cyc(2);
        chk(32'(rcbStatus), 32'h0);
        apb(1'b1, PLS_OFF_RCB, 32'h00000005);
        cyc(2);
        chk(32'(rcbStatus), 32'h1);
        apb(1'b1, PLS_OFF_TPH0, 32'h00000100);
        apb(1'b1, PLS_OFF_TPH1, 32'h000000FF);
        cyc(2);
        chk(32'(tphRequesterEnable), 32'h1);
        apb(1'b1, PLS_OFF_TPH1, 32'h00000100);
        apb(1'b1, PLS_OFF_TPH0, 32'h0000FEFF);
        cyc(2);
        chk(32'(tphRequesterEnable), 32'h2);
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, rdErr}, 32'h1);
        chk(rdData, 32'h0);
        $display("test_rcb_tph done");
    endtask

    task automatic test_notice();
        apb(1'b1, PLS_OFF_CTRL, 32'hE);
        pulse(2);
        cyc(3);
        chk(32'(link_change_notice), 32'h0);
        apb(1'b1, PLS_OFF_LSTS, 32'h7);
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, PLS_OFF_CTRL, 32'h1);
            pulse(i);
            cyc(3);
            chk(32'(link_change_notice), 32'h0);
            apb(1'b1, PLS_OFF_CTRL, 32'(1 | (2 << i)));
            cyc(2);
            chk(32'(link_change_notice), 32'h1);
            apb(1'b0, PLS_OFF_LSTS, 32'h0);
            chk(rdData & 32'h7, 32'(1 << i));
            apb(1'b1, PLS_OFF_LSTS, 32'(1 << i));
            cyc(2);
            chk(32'(link_change_notice), 32'h0);
            pulse(i);
            cyc(3);
            chk(32'(link_change_notice), 32'h1);
            apb(1'b1, PLS_OFF_LSTS, 32'(1 << i));
        end
        // Event lands in the access cycle of its own clear
        fork
            apb(1'b1, PLS_OFF_LSTS, 32'h4);
            pulse(2);
        join
        apb(1'b0, PLS_OFF_LSTS, 32'h0);
        chk(rdData & 32'h7, 32'h4);
        apb(1'b1, PLS_OFF_LSTS, 32'h7);
        $display("test_notice done");
    endtask

    task automatic test_reset();
        apb(1'b1, PLS_OFF_CTRL, 32'hF);
        apb(1'b1, PLS_OFF_RCB, 32'hF);
        apb(1'b1, PLS_OFF_TPH0, 32'h100);
        pulse(0);
        cyc(3);
        chk(32'(link_change_notice), 32'h1);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        cyc(1);
        chk(32'(ltssmState), 32'h0);
        chk(32'({link_change_notice, rcbStatus, tphRequesterEnable}), 32'h0);
        apb(1'b0, PLS_OFF_CTRL, 32'h0);
        chk(rdData, 32'h0);
        apb(1'b0, PLS_OFF_LSTS, 32'h0);
        chk(rdData, 32'h0);
        $display("test_reset done");
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        cyc(1);
        chk(32'({link_change_notice, rcbStatus, tphRequesterEnable}), 32'h0);
        test_ltssm();
        test_rcb_tph();
        test_notice();
        test_reset();
        final_report();
    end
endmodule
